// >>> logic/dxc_pkg.sv
package dxc_pkg;

	// Host I/O port addresses
	localparam logic [15:0] FUNC_PORT_ADDR = 16'h0018;
	localparam logic [15:0] EXEC_PORT_ADDR = 16'h001A;

	// Function byte layout
	localparam int CMD_MSB = 7;
	localparam int CMD_LSB = 4;
	localparam int CH_MSB  = 2;
	localparam int CH_LSB  = 0;

	// Command codes
	localparam logic [3:0] CMD_IO_ADDR  = 4'h0;
	localparam logic [3:0] CMD_MA_WRITE = 4'h2;
	localparam logic [3:0] CMD_MA_READ  = 4'h3;
	localparam logic [3:0] CMD_TC_WRITE = 4'h4;
	localparam logic [3:0] CMD_TC_READ  = 4'h5;
	localparam logic [3:0] CMD_STATUS   = 4'h6;
	localparam logic [3:0] CMD_MODE     = 4'h7;
	localparam logic [3:0] CMD_ARB      = 4'h8;
	localparam logic [3:0] CMD_MASK_SET = 4'h9;
	localparam logic [3:0] CMD_MASK_CLR = 4'hA;
	localparam logic [3:0] CMD_MCLEAR   = 4'hD;

	// Arbitration level that parks a virtual channel
	localparam logic [3:0] ARB_INACTIVE = 4'h4;

	// Reset values
	localparam logic [7:0]  FUNC_RST   = 8'h00;
	localparam logic [7:0]  MASK_RST   = 8'hFF;
	localparam logic [7:0]  STAT_RST   = 8'h00;
	localparam logic [7:0]  MODE_RST   = 8'h00;
	localparam logic [23:0] MA_RST     = 24'h000000;
	localparam logic [15:0] TC_RST     = 16'h0000;
	localparam logic [15:0] IOA_RST    = 16'h0000;
	localparam logic [3:0]  ARB0_RST   = 4'h0;
	localparam logic [3:0]  ARB4_RST   = 4'h4;
	localparam logic [1:0]  PTR_RST    = 2'h0;
	localparam logic [7:0]  RDATA_RST  = 8'h00;

	// One host I/O cycle, valid for one clock
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  data;
	} dxc_io_req_t;

	// Completion events from the transfer engine
	typedef struct packed {
		logic [7:0] tc;
		logic [7:0] req;
	} dxc_event_t;

endpackage

// >>> logic/dxc_ext_cmd.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Command 8 selects the arbitration level; only channels 0 and 4 carry one.
// R2 - Level 1-3 or 5-7 makes the channel active; level 4 makes it inactive.
// R3 - Port 0018 takes the function byte, 001A executes; 0019 and 001B do nothing.
// R4 - Any write to the function port clears the byte pointer.
// R5 - Every execute port access steps the byte pointer by one.
// R6 - Execute read returns a register byte; execute write stores one.
// R7 - Mask set, mask clear and master clear act on the function write.
// R8 - Commands 2 and 3 write and read the 24-bit memory address bytewise.
// R9 - Commands 4 and 5 write and read the 16-bit transfer count bytewise.
// R10 - Command 0 is the I/O address, 6 reads status, 7 is the mode.
// R11 - Commands 9 and A change only the named channel's mask bit.
// R12 - Function byte: command in 7-4, zero in 3, channel in 2-0.
// R13 - Arbitration level is four low bits; value F is reserved.
// R14 - Status read clears the terminal count and request flags of the group read (channels 0-3 or 4-7); reset clears all.
// R15 - Reset or master clear sets every mask bit.
// R16 - Reserved commands change nothing; execute reads under them give zero.
// R17 - Pointer zero selects the least significant byte.
module dxc_ext_cmd
(
	input  wire logic               REF_CLK,
	input  wire logic               RST_B,
	input  wire dxc_pkg::dxc_io_req_t IO_REQ,
	input  wire dxc_pkg::dxc_event_t  EVENTS,
	output logic [7:0]              IO_RDATA,
	output logic [7:0]              MASK,
	output logic [3:0]              ARB_LEVEL0,
	output logic [3:0]              ARB_LEVEL4,
	output logic [1:0]              CH_ACTIVE,
	output logic                    MCLR_PULSE
);

	function automatic logic [7:0] get_byte(input logic [23:0] v, input logic [1:0] p);
		case (p)
			2'h0: get_byte = v[7:0];
			2'h1: get_byte = v[15:8];
			2'h2: get_byte = v[23:16];
			default: get_byte = 8'h00;
		endcase
	endfunction

	function automatic logic [23:0] put_byte(input logic [23:0] v, input logic [1:0] p,
		input logic [7:0] b);
		put_byte = v;
		case (p)
			2'h0: put_byte[7:0] = b;
			2'h1: put_byte[15:8] = b;
			2'h2: put_byte[23:16] = b;
			default: put_byte = v;
		endcase
	endfunction

	function automatic logic [15:0] put_half(input logic [15:0] v, input logic [1:0] p,
		input logic [7:0] b);
		logic [23:0] w;
		w = put_byte({8'h00, v}, p, b);
		put_half = w[15:0];
	endfunction

	function automatic logic level_active(input logic [3:0] l);
		level_active = (l >= 4'h1 && l <= 4'h3) || (l >= 4'h5 && l <= 4'h7);
	endfunction

	logic [7:0]  func;
	logic [1:0]  ptr;
	logic [7:0]  stat      [2];
	logic [7:0]  mode      [8];
	logic [23:0] mem_addr  [8];
	logic [15:0] xfer_cnt  [8];
	logic [15:0] io_addr   [8];
	logic [7:0]  next_func;
	logic [1:0]  next_ptr;
	logic [7:0]  next_stat     [2];
	logic [7:0]  next_mode     [8];
	logic [23:0] next_mem_addr [8];
	logic [15:0] next_xfer_cnt [8];
	logic [15:0] next_io_addr  [8];
	logic [7:0]  next_mask;
	logic [3:0]  next_arb0;
	logic [3:0]  next_arb4;
	logic [7:0]  next_rdata;
	logic        next_mclr;
	logic        wr_func;
	logic        ex_wr;
	logic        ex_rd;
	logic [3:0]  cmd;
	logic [2:0]  ch;
	logic [3:0]  new_cmd;
	logic [2:0]  new_ch;
	logic        stat_rd;

	// Only the function and execute ports decode; neighbours are ignored
	assign wr_func = IO_REQ.wr && IO_REQ.addr == dxc_pkg::FUNC_PORT_ADDR; // [R3]
	assign ex_wr   = IO_REQ.wr && IO_REQ.addr == dxc_pkg::EXEC_PORT_ADDR; // [R3]
	assign ex_rd   = IO_REQ.rd && IO_REQ.addr == dxc_pkg::EXEC_PORT_ADDR; // [R3]
	assign cmd     = func[dxc_pkg::CMD_MSB:dxc_pkg::CMD_LSB]; // [R12]
	assign ch      = func[dxc_pkg::CH_MSB:dxc_pkg::CH_LSB]; // [R12]
	assign new_cmd = IO_REQ.data[dxc_pkg::CMD_MSB:dxc_pkg::CMD_LSB];
	assign new_ch  = IO_REQ.data[dxc_pkg::CH_MSB:dxc_pkg::CH_LSB];
	assign stat_rd = ex_rd && cmd == dxc_pkg::CMD_STATUS;

	always_comb
	begin
		next_func     = func;
		next_ptr      = ptr;
		next_mode     = mode;
		next_mem_addr = mem_addr;
		next_xfer_cnt = xfer_cnt;
		next_io_addr  = io_addr;
		next_mask     = MASK;
		next_arb0     = ARB_LEVEL0;
		next_arb4     = ARB_LEVEL4;
		next_rdata    = IO_RDATA;
		next_mclr     = 1'b0;
		// New events win over the clear of a status read
		for (int g = 0; g < 2; g++)
		begin
			next_stat[g] = (stat_rd && ch[2] == g[0]) ? dxc_pkg::STAT_RST : stat[g]; // [R14]
			next_stat[g] = next_stat[g] | {EVENTS.req[g*4 +: 4], EVENTS.tc[g*4 +: 4]};
		end
		if (wr_func)
		begin
			next_func = IO_REQ.data;
			next_ptr  = dxc_pkg::PTR_RST; // [R4]
			case (new_cmd)
				dxc_pkg::CMD_MASK_SET: next_mask[new_ch] = 1'b1; // [R7] [R11]
				dxc_pkg::CMD_MASK_CLR: next_mask[new_ch] = 1'b0; // [R7] [R11]
				dxc_pkg::CMD_MCLEAR:
				begin
					next_mask = dxc_pkg::MASK_RST; // [R7] [R15]
					next_mclr = 1'b1;
				end
				default: next_mask = MASK; // [R16]
			endcase
		end
		else if (ex_wr || ex_rd)
		begin
			next_ptr = ptr + 2'h1; // [R5]
		end
		if (ex_wr)
		begin
			// Byte at pointer, least significant first; mode and arbitration ignore the pointer [R6] [R17]
			case (cmd)
				dxc_pkg::CMD_IO_ADDR:
					next_io_addr[ch] = put_half(io_addr[ch], ptr, IO_REQ.data); // [R10]
				dxc_pkg::CMD_MA_WRITE:
					next_mem_addr[ch] = put_byte(mem_addr[ch], ptr, IO_REQ.data); // [R8]
				dxc_pkg::CMD_TC_WRITE:
					next_xfer_cnt[ch] = put_half(xfer_cnt[ch], ptr, IO_REQ.data); // [R9]
				dxc_pkg::CMD_MODE:
					next_mode[ch] = IO_REQ.data; // [R10]
				dxc_pkg::CMD_ARB:
				begin
					if (ch == 3'h0)
						next_arb0 = IO_REQ.data[3:0]; // [R1] [R13]
					else if (ch == 3'h4)
						next_arb4 = IO_REQ.data[3:0]; // [R1] [R13]
				end
				default: next_mode = mode; // [R16]
			endcase
		end
		if (ex_rd)
		begin
			case (cmd)
				dxc_pkg::CMD_IO_ADDR: next_rdata = get_byte({8'h00, io_addr[ch]}, ptr); // [R10]
				dxc_pkg::CMD_MA_READ: next_rdata = get_byte(mem_addr[ch], ptr); // [R8] [R17]
				dxc_pkg::CMD_TC_READ: next_rdata = get_byte({8'h00, xfer_cnt[ch]}, ptr); // [R9]
				dxc_pkg::CMD_STATUS:  next_rdata = stat[ch[2]]; // [R10] [R14]
				dxc_pkg::CMD_MODE:    next_rdata = mode[ch]; // [R10]
				dxc_pkg::CMD_ARB:
					next_rdata = (ch == 3'h0) ? {4'h0, ARB_LEVEL0} :
						(ch == 3'h4) ? {4'h0, ARB_LEVEL4} : 8'h00; // [R1]
				default: next_rdata = 8'h00; // [R16]
			endcase
		end
	end

	always_ff @(posedge REF_CLK)
	begin
		if (!RST_B)
		begin
			func       <= dxc_pkg::FUNC_RST;
			ptr        <= dxc_pkg::PTR_RST;
			stat       <= '{default: dxc_pkg::STAT_RST}; // [R14]
			mode       <= '{default: dxc_pkg::MODE_RST};
			mem_addr   <= '{default: dxc_pkg::MA_RST};
			xfer_cnt   <= '{default: dxc_pkg::TC_RST};
			io_addr    <= '{default: dxc_pkg::IOA_RST};
			MASK       <= dxc_pkg::MASK_RST; // [R15]
			ARB_LEVEL0 <= dxc_pkg::ARB0_RST;
			ARB_LEVEL4 <= dxc_pkg::ARB4_RST;
			CH_ACTIVE  <= {level_active(dxc_pkg::ARB4_RST), level_active(dxc_pkg::ARB0_RST)};
			IO_RDATA   <= dxc_pkg::RDATA_RST;
			MCLR_PULSE <= 1'b0;
		end
		else
		begin
			func       <= next_func;
			ptr        <= next_ptr;
			stat       <= next_stat;
			mode       <= next_mode;
			mem_addr   <= next_mem_addr;
			xfer_cnt   <= next_xfer_cnt;
			io_addr    <= next_io_addr;
			MASK       <= next_mask;
			ARB_LEVEL0 <= next_arb0;
			ARB_LEVEL4 <= next_arb4;
			CH_ACTIVE  <= {level_active(next_arb4), level_active(next_arb0)}; // [R2]
			IO_RDATA   <= next_rdata;
			MCLR_PULSE <= next_mclr;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	sequence s_func_write(logic [3:0] c);
		wr_func && new_cmd == c;
	endsequence

	property p_ptr_clear;
		wr_func |=> ptr == 2'h0;
	endproperty
	a_ptr_clear: assert property (p_ptr_clear) else $error("pointer not cleared"); // [R4]

	property p_ptr_step;
		(ex_wr || ex_rd) && !wr_func |=> ptr == $past(ptr) + 2'h1;
	endproperty
	a_ptr_step: assert property (p_ptr_step) else $error("pointer did not step"); // [R5]

	property p_mask_set;
		s_func_write(dxc_pkg::CMD_MASK_SET) |=> MASK[$past(new_ch)]
			&& ((MASK ^ $past(MASK)) & ~(8'h01 << $past(new_ch))) == 8'h00;
	endproperty
	a_mask_set: assert property (p_mask_set) else $error("single mask set wrong"); // [R11]

	property p_mask_clr;
		s_func_write(dxc_pkg::CMD_MASK_CLR) |=> !MASK[$past(new_ch)]
			&& ((MASK ^ $past(MASK)) & ~(8'h01 << $past(new_ch))) == 8'h00;
	endproperty
	a_mask_clr: assert property (p_mask_clr) else $error("single mask clear wrong"); // [R7]

	property p_mclear;
		s_func_write(dxc_pkg::CMD_MCLEAR) |=> MASK == 8'hFF && MCLR_PULSE ##1 !MCLR_PULSE;
	endproperty
	a_mclear: assert property (p_mclear) else $error("master clear failed"); // [R15]

	property p_stat_clear;
		stat_rd && EVENTS == '0 |=> stat[$past(ch[2])] == 8'h00;
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status not cleared"); // [R14]

	property p_rsv_read;
		ex_rd && (cmd == 4'h1 || cmd == 4'hB || cmd == 4'hC || cmd == 4'hE || cmd == 4'hF)
			|=> IO_RDATA == 8'h00;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved read not zero"); // [R16]

	property p_ma_lsb;
		ex_wr && cmd == dxc_pkg::CMD_MA_WRITE && ptr == 2'h0
			|=> mem_addr[$past(ch)][7:0] == $past(IO_REQ.data);
	endproperty
	a_ma_lsb: assert property (p_ma_lsb) else $error("address byte 0 wrong"); // [R8]

	property p_tc_msb;
		ex_wr && cmd == dxc_pkg::CMD_TC_WRITE && ptr == 2'h1
			|=> xfer_cnt[$past(ch)][15:8] == $past(IO_REQ.data);
	endproperty
	a_tc_msb: assert property (p_tc_msb) else $error("count byte 1 wrong"); // [R9]

	property p_arb_active;
		ex_wr && cmd == dxc_pkg::CMD_ARB && ch == 3'h0
			&& IO_REQ.data[3:0] == dxc_pkg::ARB_INACTIVE
			|=> !CH_ACTIVE[0] && ARB_LEVEL0 == dxc_pkg::ARB_INACTIVE;
	endproperty
	a_arb_active: assert property (p_arb_active) else $error("level 4 left active"); // [R2]

endmodule

// >>> verif/dxc_host_model.sv
`timescale 1ns/1ps
module dxc_host_model
(
	input  wire logic            ref_clk,
	input  wire logic [7:0]      io_rdata,
	output var dxc_pkg::dxc_io_req_t io_req
);
	initial io_req = '{1'b0, 1'b0, 16'hFFFF, 8'hFF};
	// One strobe cycle, then bus released showing inverted values
	task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		io_req <= '{w, ~w, a, d};
		@(posedge ref_clk);
		io_req <= '{1'b0, 1'b0, ~a, ~d};
		#1;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		cyc(1'b1, a, d);
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		cyc(1'b0, a, 8'h00);
		d = io_rdata;
	endtask
endmodule

// >>> verif/test_dxc_ext_cmd.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_dxc_ext_cmd;
	logic                 ref_clk;
	logic                 rst_b;
	dxc_pkg::dxc_io_req_t io_req;
	dxc_pkg::dxc_event_t  events;
	logic [7:0]           io_rdata;
	logic [7:0]           mask;
	logic [7:0]           exp;
	logic [7:0]           rd;
	logic [3:0]           arb_level0;
	logic [3:0]           arb_level4;
	logic [1:0]           ch_active;
	logic                 mclr_pulse;
	int                   err_total;
	int                   tests_run;
	int                   cycles;

	dxc_ext_cmd dut (.REF_CLK(ref_clk), .RST_B(rst_b), .IO_REQ(io_req), .EVENTS(events),
		.IO_RDATA(io_rdata), .MASK(mask), .ARB_LEVEL0(arb_level0), .ARB_LEVEL4(arb_level4),
		.CH_ACTIVE(ch_active), .MCLR_PULSE(mclr_pulse));
	dxc_host_model host (.ref_clk(ref_clk), .io_rdata(io_rdata), .io_req(io_req));

	initial
	begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			$display("Error at %0t: timeout", $time);
			err_total++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic fn(input logic [3:0] c, input logic [2:0] ch);
		host.wr(dxc_pkg::FUNC_PORT_ADDR, {c, 1'b0, ch});
	endtask
	task automatic ex_wr(input logic [7:0] d);
		host.wr(dxc_pkg::EXEC_PORT_ADDR, d);
	endtask
	task automatic ex_chk(input logic [7:0] e);
		host.rd(dxc_pkg::EXEC_PORT_ADDR, rd);
		`CHK(rd, e)
	endtask

	task automatic t_reset();
		`CHK(mask, 8'hFF)
		`CHK({arb_level0, arb_level4, ch_active, mclr_pulse}, 11'h020)
		fn(4'h6, 3'd0);
		ex_chk(8'h00);
		$display("reset test done");
	endtask
	task automatic t_mem();
		fn(4'h2, 3'd2);
		ex_wr(8'h56);
		ex_wr(8'h34);
		ex_wr(8'h12);
		fn(4'h3, 3'd2);
		ex_chk(8'h56);
		ex_chk(8'h34);
		fn(4'h3, 3'd2);
		ex_chk(8'h56);
		host.wr(16'h0019, 8'h32);
		host.wr(16'h001B, 8'h32);
		ex_chk(8'h34);
		ex_chk(8'h12);
		$display("memory address test done");
	endtask
	task automatic t_regs();
		fn(4'h4, 3'd5);
		ex_wr(8'hAB);
		ex_wr(8'hCD);
		fn(4'h5, 3'd5);
		ex_chk(8'hAB);
		ex_chk(8'hCD);
		fn(4'h0, 3'd1);
		ex_wr(8'h11);
		ex_wr(8'h22);
		fn(4'h0, 3'd1);
		ex_chk(8'h11);
		ex_chk(8'h22);
		fn(4'h7, 3'd3);
		ex_wr(8'h4C);
		fn(4'h7, 3'd3);
		ex_chk(8'h4C);
		$display("count and mode test done");
	endtask
	task automatic t_mask();
		exp = 8'hFF;
		for (int i = 0; i < 16; i++)
		begin
			fn(i < 8 ? 4'hA : 4'h9, i[2:0]);
			exp[i[2:0]] = i >= 8;
			`CHK(mask, exp)
		end
		fn(4'hA, 3'd3);
		fn(4'hD, 3'd0);
		`CHK({mask, mclr_pulse}, 9'h1FF)
		@(posedge ref_clk);
		#1;
		`CHK(mclr_pulse, 1'b0)
		$display("mask test done");
	endtask
	task automatic t_arb();
		for (int v = 0; v < 15; v++)
		begin
			fn(4'h8, 3'd0);
			ex_wr(8'(v));
			@(posedge ref_clk);
			#1;
			`CHK(arb_level0, v[3:0])
			`CHK(ch_active[0], (v % 4 != 0) && v < 8)
		end
		fn(4'h8, 3'd4);
		ex_wr(8'h07);
		fn(4'h8, 3'd2);
		ex_wr(8'h03);
		@(posedge ref_clk);
		#1;
		`CHK({arb_level0, arb_level4, ch_active}, 10'h39E)
		fn(4'h8, 3'd4);
		ex_chk(8'h07);
		$display("arbitration test done");
	endtask
	task automatic t_status();
		@(posedge ref_clk);
		events <= '{tc: 8'h20, req: 8'h02};
		@(posedge ref_clk);
		events <= '{tc: 8'h00, req: 8'h00};
		fn(4'h6, 3'd4);
		ex_chk(8'h02);
		fn(4'h6, 3'd4);
		ex_chk(8'h00);
		fn(4'h6, 3'd0);
		ex_chk(8'h20);
		$display("status test done");
	endtask
	task automatic t_rsvd();
		exp = mask;
		foreach (exp[i])
		begin
			if (i < 5)
			begin
				fn(i == 0 ? 4'h1 : 4'hA + 4'(i) + 4'(i > 2), 3'd2);
				ex_wr(8'hFF);
				fn(i == 0 ? 4'h1 : 4'hA + 4'(i) + 4'(i > 2), 3'd2);
				ex_chk(8'h00);
			end
		end
		`CHK(mask, exp)
		fn(4'h3, 3'd2);
		ex_chk(8'h56);
		$display("reserved command test done");
	endtask

	initial
	begin
		rst_b = 1'b0;
		events = '{tc: 8'h00, req: 8'h00};
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		t_reset();
		t_mem();
		t_regs();
		t_mask();
		t_arb();
		t_status();
		t_rsvd();
		finish_test();
	end
endmodule
